// ===== verilog/lsi_map.svh
// Register offsets, field positions, reset values and timing counts of the line status block.
// Included by the package and the design modules; holds definitions only.
`ifndef LSI_MAP_SVH
`define LSI_MAP_SVH

// Register offsets on the control interface
`define LSI_OFS_LINE_CONDITION  8'h18
`define LSI_OFS_EVENT_LATCH_A   8'h19
`define LSI_OFS_EVENT_LATCH_B   8'h1A

// Line condition monitor fields
`define LSI_LCM_LOOPBACK_BIT    5
`define LSI_LCM_ATTEN_MSB       4
`define LSI_LCM_ATTEN_LSB       0

// Event latch A field positions
`define LSI_EVA_EQUALIZER       7
`define LSI_EVA_INBAND_ACT      6
`define LSI_EVA_INBAND_DEACT    5
`define LSI_EVA_PATTERN_SYNC    4
`define LSI_EVA_TX_CLOCK_LOSS   3
`define LSI_EVA_DRIVER_FAIL     2
`define LSI_EVA_ALARM_IND       1
`define LSI_EVA_SIGNAL_LOSS     0

// Event latch B field positions
`define LSI_EVB_WAVE_OVERFLOW   7
`define LSI_EVB_JITTER_OVER     6
`define LSI_EVB_JITTER_UNDER    5
`define LSI_EVB_PATTERN_ERROR   4
`define LSI_EVB_EXCESS_ZEROS    3
`define LSI_EVB_CODE_VIOLATION  2
`define LSI_EVB_SECOND_TIMER    1
`define LSI_EVB_COUNTER_OVER    0

// Reset values
`define LSI_RST_BYTE            8'h00
`define LSI_RST_EVENTS          16'h0000
`define LSI_UNMAPPED_DATA       8'h00

// Transmit clock loss: master clock cycles without a toggle
`define LSI_TRANSMIT_LINE_CLOCK_LOSS_CYCLES    7'h46

`endif

// ===== verilog/lsi_pkg.sv
// Types shared by the line status block modules.
// Assumes lsi_map.svh is on the include path.
`include "lsi_map.svh"

package lsi_pkg;

	// Register state of the status and event block
	typedef struct packed {
		logic [7:0]  latch_a;
		logic [7:0]  latch_b;
		logic [15:0] prev_status;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        irq;
	} lsi_state_s;

	// State of the transmit clock loss detector
	typedef struct packed {
		logic [2:0] sync;
		logic       level;
		logic [6:0] idle_count;
		logic       loss;
	} lsi_transmit_line_clock_state_s;

	typedef logic [7:0] lsi_byte_t;

endpackage

// ===== verilog/lsi_transmit_line_clock_loss.sv
// Transmit clock loss detector for the line status block.
// Assumes transmit_line_clock is an asynchronous pin and clk_sys is the master clock.
`timescale 1ns/10ps
`default_nettype none
`include "lsi_map.svh"

module lsi_transmit_line_clock_loss (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic transmit_line_clock,
	output logic      tx_clock_loss_status
);
	import lsi_pkg::*;

	lsi_transmit_line_clock_state_s st_q;
	lsi_transmit_line_clock_state_s st_d;
	logic            changed;

	// Pin passes three flops; a toggle counts once stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], transmit_line_clock};
		changed = (st_q.sync[2] == st_q.sync[1]) && (st_q.sync[2] != st_q.level);
		if (changed) begin
			st_d.level = st_q.sync[2];
			st_d.idle_count = 7'h00;
		end else if (st_q.idle_count != 7'h7F) begin
			st_d.idle_count = st_q.idle_count + 7'h01;
		end
		st_d.loss = (st_d.idle_count > `LSI_TRANSMIT_LINE_CLOCK_LOSS_CYCLES);
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tx_clock_loss_status = st_q.loss;

endmodule // lsi_transmit_line_clock_loss

`default_nettype wire

// ===== verilog/lsi_line_status.sv
// Line condition monitor and clear-on-read event latches of a T1/E1/J1 line interface.
// Assumes detector status inputs are synchronous to clk_sys and reads arrive as one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
`include "lsi_map.svh"

// What this block does
// - Line condition bit 5 shows remote loopback state live.
// - Reading an event register returns it, clears it and withdraws its requests.
// - Event A bit 7 latches equalizer out of range.
// - Event A bit 6 latches inband loopback activate code.
// - Event A bit 5 latches inband loopback deactivate code.
// - Event A bit 4 latches pattern synchronisation status events.
// - Event A bit 3 latches transmit clock loss events.
// - Event A bit 2 latches line driver failure events.
// - Event A bit 1 latches alarm indication signal events.
// - Event A bit 0 latches loss of signal events.
// - Event B bit 7 latches waveform amplitude overflow.
// - Event B bit 6 latches jitter buffer overflow.
// - Event B bit 5 latches jitter buffer underflow.
// - Event B bit 4 latches pattern bit error.
// - Event B bit 3 latches excessive zeros.
// - Event B bit 2 latches code violation.
// - Event B bit 1 latches each one-second timer expiry.
// - Event B bit 0 latches error counter overflow.
// - Unmasked status raises event on rise, or any change with edge select.
// - Transmit clock loss when no toggle for over 70 master clocks.
module lsi_line_status (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Control interface read port
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_rd_en,
	output lsi_pkg::lsi_byte_t reg_rd_data,
	output logic               reg_rd_valid,
	// Live line condition
	input  wire logic          remote_loopback_active,
	input  wire logic [4:0]    attenuation_estimate,
	// Detector status levels and the transmit clock pin, event latch A sources
	input  wire logic          equalizer_range_status,
	input  wire logic          inband_activate_status,
	input  wire logic          inband_deactivate_status,
	input  wire logic          pattern_sync_status,
	input  wire logic          transmit_line_clock,
	input  wire logic          driver_failure_status,
	input  wire logic          alarm_indication_status,
	input  wire logic          signal_loss_status,
	// Detector status levels, event latch B sources
	input  wire logic          waveform_amplitude_overflow_status,
	input  wire logic          jitter_buffer_overflow_status,
	input  wire logic          jitter_buffer_underflow_status,
	input  wire logic          pattern_bit_error_status,
	input  wire logic          excess_zeros_status,
	input  wire logic          code_violation_status,
	input  wire logic          second_timer_expiry_status,
	input  wire logic          error_counter_overflow_status,
	// Per-event mask and edge select, bits 15-8 for latch B, 7-0 for latch A
	input  wire logic [15:0]   event_mask_bit,
	input  wire logic [15:0]   event_edge_select_bit,
	// Combined interrupt request and transmit clock loss level
	output logic               interrupt_request,
	output logic               tx_clock_loss_status
);
	import lsi_pkg::*;

	lsi_state_s  st_q;
	lsi_state_s  st_d;
	logic        transmit_line_clock_loss;
	logic [15:0] status_now;
	logic [15:0] event_hit;
	logic [7:0]  line_condition;
	logic        read_a;
	logic        read_b;

	// Transmit clock watchdog on the pin
	lsi_transmit_line_clock_loss u_transmit_line_clock_loss (
		.clk_sys              (clk_sys),
		.rst_n                (rst_n),
		.transmit_line_clock  (transmit_line_clock),
		.tx_clock_loss_status (transmit_line_clock_loss)
	);

	// Gather detector levels into event positions
	always_comb begin
		status_now = `LSI_RST_EVENTS;
		status_now[`LSI_EVA_EQUALIZER]            = equalizer_range_status;
		status_now[`LSI_EVA_INBAND_ACT]           = inband_activate_status;
		status_now[`LSI_EVA_INBAND_DEACT]         = inband_deactivate_status;
		status_now[`LSI_EVA_PATTERN_SYNC]         = pattern_sync_status;
		status_now[`LSI_EVA_TX_CLOCK_LOSS]        = transmit_line_clock_loss;
		status_now[`LSI_EVA_DRIVER_FAIL]          = driver_failure_status;
		status_now[`LSI_EVA_ALARM_IND]            = alarm_indication_status;
		status_now[`LSI_EVA_SIGNAL_LOSS]          = signal_loss_status;
		status_now[8 + `LSI_EVB_WAVE_OVERFLOW]    = waveform_amplitude_overflow_status;
		status_now[8 + `LSI_EVB_JITTER_OVER]      = jitter_buffer_overflow_status;
		status_now[8 + `LSI_EVB_JITTER_UNDER]     = jitter_buffer_underflow_status;
		status_now[8 + `LSI_EVB_PATTERN_ERROR]    = pattern_bit_error_status;
		status_now[8 + `LSI_EVB_EXCESS_ZEROS]     = excess_zeros_status;
		status_now[8 + `LSI_EVB_CODE_VIOLATION]   = code_violation_status;
		status_now[8 + `LSI_EVB_SECOND_TIMER]     = second_timer_expiry_status;
		status_now[8 + `LSI_EVB_COUNTER_OVER]     = error_counter_overflow_status;
	end

	// Per-event edge qualifier: rise, or any change when edge select is set
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_edge
			assign event_hit[gi] = !event_mask_bit[gi] &&
				(event_edge_select_bit[gi] ? (status_now[gi] != st_q.prev_status[gi])
				                           : (status_now[gi] && !st_q.prev_status[gi]));
		end
	endgenerate

	// Live line condition byte, reserved bits read zero
	always_comb begin
		line_condition = `LSI_RST_BYTE;
		line_condition[`LSI_LCM_LOOPBACK_BIT] = remote_loopback_active;
		line_condition[`LSI_LCM_ATTEN_MSB:`LSI_LCM_ATTEN_LSB] = attenuation_estimate;
	end

	assign read_a = reg_rd_en && (reg_addr == `LSI_OFS_EVENT_LATCH_A);
	assign read_b = reg_rd_en && (reg_addr == `LSI_OFS_EVENT_LATCH_B);

	// Next state: latch events, clear on read, new event wins over the clear
	always_comb begin
		st_d = st_q;
		st_d.prev_status = status_now;
		st_d.rd_valid = reg_rd_en;
		st_d.latch_a = (read_a ? `LSI_RST_BYTE : st_q.latch_a) | event_hit[7:0];
		st_d.latch_b = (read_b ? `LSI_RST_BYTE : st_q.latch_b) | event_hit[15:8];
		if (reg_rd_en) begin
			unique case (reg_addr)
				`LSI_OFS_LINE_CONDITION: st_d.rd_data = line_condition;
				`LSI_OFS_EVENT_LATCH_A:  st_d.rd_data = st_q.latch_a;
				`LSI_OFS_EVENT_LATCH_B:  st_d.rd_data = st_q.latch_b;
				default:                 st_d.rd_data = `LSI_UNMAPPED_DATA;
			endcase
		end
		// Request withdrawn once all unmasked latched bits are gone
		st_d.irq = |({st_d.latch_b, st_d.latch_a} & ~event_mask_bit);
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rd_data          = st_q.rd_data;
	assign reg_rd_valid         = st_q.rd_valid;
	assign interrupt_request    = st_q.irq;
	assign tx_clock_loss_status = transmit_line_clock_loss;

endmodule // lsi_line_status

`default_nettype wire

// ===== testbench/lsi_line_status_assertions.sv
// Checker for the line status block: read port, line condition and clock loss.
// Bound to lsi_line_status; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module lsi_line_status_checker (
	input wire logic               clk_sys,
	input wire logic               rst_n,
	input wire logic [7:0]         reg_addr,
	input wire logic               reg_rd_en,
	input wire lsi_pkg::lsi_byte_t reg_rd_data,
	input wire logic               reg_rd_valid,
	input wire logic               remote_loopback_active,
	input wire logic [4:0]         attenuation_estimate,
	input wire logic               transmit_line_clock,
	input wire logic [15:0]        event_mask_bit,
	input wire logic               interrupt_request,
	input wire logic               tx_clock_loss_status
);
	import lsi_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [6:0] idle_q;
	logic [6:0] idle_d;
	logic       pin_q;
	// Clocks since the transmit clock pin last changed, saturating
	always_comb idle_d = (transmit_line_clock != pin_q) ? 7'h00 : idle_q + {6'h00, idle_q != 7'h7F};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idle_q <= 7'h00;
			pin_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
			pin_q <= transmit_line_clock;
		end
	end
	rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
	rd_single_a: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("stray read valid");
	rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data)) else $error("read data moved");
	loopback_bit_a: assert property (reg_rd_en && reg_addr == 8'h18 |=>
		reg_rd_data[5] == $past(remote_loopback_active)) else $error("loopback bit wrong");
	atten_code_a: assert property (reg_rd_en && reg_addr == 8'h18 |=>
		reg_rd_data[4:0] == $past(attenuation_estimate)) else $error("attenuation wrong");
	masked_quiet_a: assert property (event_mask_bit == 16'hFFFF && $past(event_mask_bit) == 16'hFFFF
		|-> !interrupt_request) else $error("request while all masked");
	loss_late_a: assert property (tx_clock_loss_status |-> idle_q >= 7'h46) else $error("loss too early");
	loss_due_a: assert property (idle_q == 7'h5A |-> tx_clock_loss_status) else $error("loss missing");
	cover property (reg_rd_en && reg_addr == 8'h19 ##1 reg_rd_data != 8'h00);
	cover property ($rose(interrupt_request));
	cover property ($rose(tx_clock_loss_status));
endmodule // lsi_line_status_checker
bind lsi_line_status lsi_line_status_checker chk_u (.*);
`default_nettype wire

// ===== testbench/lsi_line_status_bench.sv
// Self-checking bench for the line status block.
// Drives all ports directly; the clock loss detector is fed by a toggling pin.
`timescale 1ns/10ps
`default_nettype none
module lsi_line_status_bench;
	import lsi_pkg::*;
	logic        clk_sys, rst_n, reg_rd_en, remote_loopback_active, transmit_line_clock, tx_run;
	logic        reg_rd_valid, interrupt_request, tx_clock_loss_status;
	logic [7:0]  reg_addr;
	logic [4:0]  attenuation_estimate;
	logic [15:0] st, event_mask_bit, event_edge_select_bit;
	lsi_byte_t   reg_rd_data;
	int          n_errors, checks_done;
	lsi_line_status dut_u (.*, .equalizer_range_status(st[7]), .inband_activate_status(st[6]),
		.inband_deactivate_status(st[5]), .pattern_sync_status(st[4]), .driver_failure_status(st[2]),
		.alarm_indication_status(st[1]), .signal_loss_status(st[0]),
		.waveform_amplitude_overflow_status(st[15]), .jitter_buffer_overflow_status(st[14]),
		.jitter_buffer_underflow_status(st[13]), .pattern_bit_error_status(st[12]),
		.excess_zeros_status(st[11]), .code_violation_status(st[10]),
		.second_timer_expiry_status(st[9]), .error_counter_overflow_status(st[8]));
	// Clock, and a transmit clock pin toggling every fourth clock so the three-flop filter accepts each level
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always begin
		repeat (4) @(posedge clk_sys);
		if (tx_run) transmit_line_clock <= ~transmit_line_clock;
	end
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1 chk($sformatf("read %h", a), {1'b1, e}, {reg_rd_valid, reg_rd_data});
	endtask
	task automatic setst(input logic [15:0] v);
		@(posedge clk_sys);
		st <= v;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		{rst_n, reg_rd_en, remote_loopback_active, transmit_line_clock, reg_addr} = '0;
		{attenuation_estimate, st, event_mask_bit, event_edge_select_bit} = '0;
		tx_run = 1'b1;
		n_errors = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h19, 8'h00);
		rd(8'h1A, 8'h00);
		rd(8'h1B, 8'h00);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			remote_loopback_active <= i[0];
			attenuation_estimate <= 5'h0F * i[4:0];
			rd(8'h18, {2'b00, i[0], 5'h0F * i[4:0]});
		end
		for (int i = 0; i < 16; i++) if (i != 3) begin
			setst(16'h0001 << i);
			chk("irq set", 9'h001, {8'h00, interrupt_request});
			rd(i < 8 ? 8'h19 : 8'h1A, 8'h01 << i[2:0]);
			rd(i < 8 ? 8'h19 : 8'h1A, 8'h00);
			chk("irq clear", 9'h000, {8'h00, interrupt_request});
			setst(16'h0000);
		end
		@(posedge clk_sys);
		event_edge_select_bit <= 16'hFFFF;
		for (int k = 0; k < 2; k++) begin
			setst(k == 0 ? 16'hFFF7 : 16'h0000);
			rd(8'h19, 8'hF7);
			rd(8'h1A, 8'hFF);
		end
		@(posedge clk_sys);
		event_mask_bit <= 16'hFFFF;
		event_edge_select_bit <= 16'h0000;
		setst(16'hFFF7);
		chk("irq masked", 9'h000, {8'h00, interrupt_request});
		rd(8'h19, 8'h00);
		rd(8'h1A, 8'h00);
		@(posedge clk_sys);
		event_mask_bit <= 16'h0000;
		tx_run <= 1'b0;
		repeat (60) @(posedge clk_sys);
		#1 chk("loss early", 9'h000, {8'h00, tx_clock_loss_status});
		repeat (30) @(posedge clk_sys);
		#1 chk("loss late", 9'h001, {8'h00, tx_clock_loss_status});
		rd(8'h19, 8'h08);
		report_and_stop();
	end
endmodule // lsi_line_status_bench
`default_nettype wire
